/* File: design/adcs_ctrl.sv */
// Summary of operation
// - sclk held low beyond the timeout drops any partial serial frame.
// - with select tied low, frames are counted in 16-bit units alone.
// - a single shot converts once, stores the result, then powers down.
// - continuous mode restarts a conversion as soon as one completes.
// - each conversion lasts the modulator ticks chosen by the rate code.
// - a read returns the last completed result, never a partial one.
// - the 3-bit input select picks single, differential or vs-input-3.
// - single-ended selections tie the converter negative input to ground.
// - single-ended results below zero are clamped to code zero.
// - the modulator clock is the 1 MHz oscillator divided by four.
// - serial output floats while select is high, drives while low.
// - serial input is sampled on each falling sclk edge.
// - serial output changes after a rising sclk edge mid-frame, and flags new data between frames.
// - the mode bit picks single shot at 1, continuous at 0; 1 at reset.
// - start bit powers up and runs one conversion, ignored while busy.
`default_nettype none
module adcs_ctrl
  import adcs_pkg::*;
#(
  parameter int TIMEOUT_CYC = adcs_pkg::SCLK_LOW_TIMEOUT_CYC,
  parameter int FIFO_DEPTH  = 16
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  // serial port
  input  wire logic                       sclk,
  input  wire logic                       csN,
  input  wire logic                       din,
  output var  logic                       serialOutReady,
  output var  logic                       serialOutReadyOe,
  // sample stream from the modulator filter
  input  wire logic                       smpValid,
  input  wire logic [adcs_pkg::RES_BITS-1:0] smpData,
  output var  logic                       smpReady,
  // analog control and status
  output var  adcs_pkg::adcs_mux_t        muxSel,
  output var  logic                       modClk,
  output var  logic                       powerDown,
  output var  logic                       dataNew
);
  import adcs_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYC);
  localparam logic [4:0]    FRAME_LAST   = 5'(FRAME_BITS - 1);

  // ------------------------------------------------------------
  // modulator clock and sample buffer
  // ------------------------------------------------------------
  logic                modTick;
  logic                fifoValid;
  logic [RES_BITS-1:0] fifoData;
  logic                fifoPop;

  adcs_rate_gen #(
    .OSC_DIV (OSC_DIV),
    .MOD_DIV (MOD_DIV)
  ) u_rate (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .modTick (modTick),
    .modClk  (modClk)
  );

  adcs_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .wrValid (smpValid),
    .wrData  (smpData),
    .wrReady (smpReady),
    .rdValid (fifoValid),
    .rdData  (fifoData),
    .rdReady (fifoPop)
  );

  // ------------------------------------------------------------
  // serial port
  // ------------------------------------------------------------
  logic                  sclkPrev_q, sclkPrev_d;
  logic [4:0]            bitCnt_q, bitCnt_d;
  logic                  midFrame_q, midFrame_d;
  logic [FRAME_BITS-1:0] shIn_q, shIn_d;
  logic [FRAME_BITS-1:0] shOut_q, shOut_d;
  logic                  sdo_q, sdo_d;
  logic                  sdoOe_q, sdoOe_d;
  logic [TW-1:0]         lowCnt_q, lowCnt_d;
  logic                  frameDone;
  logic                  sclkRise, sclkFall, timedOut;
  logic [RES_BITS-1:0]   result_q;
  logic                  dataNew_q;

  always_comb begin
    sclkPrev_d = sclk;
    sclkRise   = ~sclkPrev_q & sclk;
    sclkFall   = sclkPrev_q & ~sclk;
    lowCnt_d   = lowCnt_q;
    if (sclk) begin
      lowCnt_d = '0;
    end else if (lowCnt_q != TIMEOUT_LAST) begin
      lowCnt_d = lowCnt_q + 1'b1;
    end
    timedOut   = ~sclk && (lowCnt_q == TIMEOUT_LAST);
    bitCnt_d   = bitCnt_q;
    midFrame_d = midFrame_q;
    shIn_d     = shIn_q;
    shOut_d    = shOut_q;
    sdo_d      = sdo_q;
    sdoOe_d    = ~csN;
    frameDone  = 1'b0;
    if (csN || timedOut) begin
      // select high or stuck clock: abandon the frame
      bitCnt_d   = '0;
      midFrame_d = 1'b0;
    end else begin
      if (sclkRise) begin
        midFrame_d = 1'b1;
        if (!midFrame_q) begin
          // snapshot of the stored result for the whole frame
          shOut_d = {result_q, 4'h0} << 1;
          sdo_d   = result_q[RES_BITS-1];
        end else begin
          shOut_d = shOut_q << 1;
          sdo_d   = shOut_q[FRAME_BITS-1];
        end
      end
      if (sclkFall) begin
        shIn_d   = {shIn_q[FRAME_BITS-2:0], din};
        bitCnt_d = bitCnt_q + 1'b1;
        if (bitCnt_q == FRAME_LAST) begin
          // bit count alone ends the frame when select stays low
          bitCnt_d   = '0;
          midFrame_d = 1'b0;
          frameDone  = 1'b1;
        end
      end
    end
    // between frames the output line flags fresh data, low = ready
    if (!midFrame_d) begin
      sdo_d = ~(dataNew_q & ~frameDone);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev_q <= 1'b0;
      bitCnt_q   <= '0;
      midFrame_q <= 1'b0;
      shIn_q     <= '0;
      shOut_q    <= '0;
      sdo_q      <= 1'b1;
      sdoOe_q    <= 1'b0;
      lowCnt_q   <= '0;
    end else begin
      sclkPrev_q <= sclkPrev_d;
      bitCnt_q   <= bitCnt_d;
      midFrame_q <= midFrame_d;
      shIn_q     <= shIn_d;
      shOut_q    <= shOut_d;
      sdo_q      <= sdo_d;
      sdoOe_q    <= sdoOe_d;
      lowCnt_q   <= lowCnt_d;
    end
  end

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  adcs_cfg_t cfg_q, cfg_d, cfgIn;
  logic      startReq;

  always_comb begin
    cfgIn    = adcs_cfg_t'(shIn_d);
    cfg_d    = cfg_q;
    startReq = 1'b0;
    if (frameDone) begin
      cfg_d         = cfgIn;
      cfg_d.startSs = 1'b0;
      startReq      = cfgIn.startSs;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= adcs_cfg_t'(CFG_RESET);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ------------------------------------------------------------
  // input multiplexer
  // ------------------------------------------------------------
  adcs_mux_t mux_q, mux_d;

  always_comb begin
    mux_d = '{posIdx: 2'h0, negIdx: 2'h1, negToGnd: 1'b0};
    unique case (cfg_q.inSel)
      3'h0: mux_d = '{posIdx: 2'h0, negIdx: 2'h1, negToGnd: 1'b0};
      3'h1: mux_d = '{posIdx: 2'h0, negIdx: 2'h3, negToGnd: 1'b0};
      3'h2: mux_d = '{posIdx: 2'h1, negIdx: 2'h3, negToGnd: 1'b0};
      3'h3: mux_d = '{posIdx: 2'h2, negIdx: 2'h3, negToGnd: 1'b0};
      3'h4: mux_d = '{posIdx: 2'h0, negIdx: 2'h0, negToGnd: 1'b1};
      3'h5: mux_d = '{posIdx: 2'h1, negIdx: 2'h0, negToGnd: 1'b1};
      3'h6: mux_d = '{posIdx: 2'h2, negIdx: 2'h0, negToGnd: 1'b1};
      3'h7: mux_d = '{posIdx: 2'h3, negIdx: 2'h0, negToGnd: 1'b1};
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mux_q <= '{posIdx: 2'h0, negIdx: 2'h1, negToGnd: 1'b0};
    end else begin
      mux_q <= mux_d;
    end
  end

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  adcs_conv_t          st_q, st_d;
  logic [LEN_BITS-1:0] convCnt_q, convCnt_d;
  logic [RES_BITS-1:0] lastSmp_q, lastSmp_d;
  logic [RES_BITS-1:0] result_d, finalSmp;
  logic                dataNew_d, convEnd;
  logic                powerDown_q, powerDown_d;

  always_comb begin
    st_d      = st_q;
    convCnt_d = convCnt_q;
    lastSmp_d = lastSmp_q;
    result_d  = result_q;
    dataNew_d = dataNew_q;
    convEnd   = 1'b0;
    // samples drain only while converting; the buffer backs up otherwise
    fifoPop   = (st_q == CONV_RUN) && modTick;
    finalSmp  = (fifoPop && fifoValid) ? fifoData : lastSmp_q;
    unique case (st_q)
      CONV_DOWN: begin
        if (!cfg_q.oneShot || startReq) begin
          st_d      = CONV_RUN;
          convCnt_d = '0;
        end
      end
      CONV_RUN: begin
        if (fifoPop) begin
          lastSmp_d = finalSmp;
          convCnt_d = convCnt_q + 1'b1;
          if (convCnt_q >= convLen(cfg_q.rate) - 1'b1) begin
            convEnd   = 1'b1;
            convCnt_d = '0;
            if (cfg_q.oneShot) begin
              st_d = CONV_DOWN;
            end
          end
        end
      end
    endcase
    if (frameDone) begin
      dataNew_d = 1'b0;
    end
    if (convEnd) begin
      result_d  = finalSmp;
      if (mux_q.negToGnd && finalSmp[RES_BITS-1]) begin
        result_d = '0;
      end
      dataNew_d = 1'b1;
    end
    powerDown_d = (st_d == CONV_DOWN);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= CONV_DOWN;
      convCnt_q <= '0;
      lastSmp_q <= '0;
      result_q  <= '0;
      dataNew_q <= 1'b0;
      powerDown_q <= 1'b1;
    end else begin
      st_q      <= st_d;
      convCnt_q <= convCnt_d;
      lastSmp_q <= lastSmp_d;
      result_q  <= result_d;
      dataNew_q <= dataNew_d;
      powerDown_q <= powerDown_d;
    end
  end

  assign serialOutReady   = sdo_q;
  assign serialOutReadyOe = sdoOe_q;
  assign muxSel           = mux_q;
  assign powerDown        = powerDown_q;
  assign dataNew          = dataNew_q;

endmodule
`default_nettype wire

/* File: design/adcs_pkg.sv */
`default_nettype none
package adcs_pkg;

  // ------------------------------------------------------------
  // clocking
  // ------------------------------------------------------------
  localparam int MCLK_HZ = 100_000_000;
  localparam int OSC_HZ  = 1_000_000;
  localparam int OSC_DIV = MCLK_HZ / OSC_HZ;
  localparam int MOD_DIV = 4;
  localparam int SCLK_LOW_TIMEOUT_US = 30800;
  // longest time: rounds down
  localparam int SCLK_LOW_TIMEOUT_CYC =
    SCLK_LOW_TIMEOUT_US * (MCLK_HZ / 1_000_000);

  // ------------------------------------------------------------
  // serial frame and configuration word
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RES_BITS   = 12;
  localparam int RATE_BITS  = 3;
  localparam int LEN_BITS   = 11;

  typedef struct packed {
    logic       startSs;
    logic [2:0] inSel;
    logic [2:0] spare0;
    logic       oneShot;
    logic [2:0] rate;
    logic [4:0] spare1;
  } adcs_cfg_t;

  localparam logic [15:0] CFG_RESET = 16'h0180;

  typedef struct packed {
    logic [1:0] posIdx;
    logic [1:0] negIdx;
    logic       negToGnd;
  } adcs_mux_t;

  typedef enum logic {
    CONV_DOWN,
    CONV_RUN
  } adcs_conv_t;

  // modulator ticks per conversion, per rate code
  localparam logic [LEN_BITS-1:0] CONV_LEN_0 = 11'h7A1;
  localparam logic [LEN_BITS-1:0] CONV_LEN_1 = 11'h3E8;
  localparam logic [LEN_BITS-1:0] CONV_LEN_2 = 11'h1FE;
  localparam logic [LEN_BITS-1:0] CONV_LEN_3 = 11'h10F;
  localparam logic [LEN_BITS-1:0] CONV_LEN_4 = 11'h09C;
  localparam logic [LEN_BITS-1:0] CONV_LEN_5 = 11'h068;
  localparam logic [LEN_BITS-1:0] CONV_LEN_6 = 11'h04B;

  function automatic logic [LEN_BITS-1:0] convLen(
    input logic [RATE_BITS-1:0] code);
    unique case (code)
      3'h0:    convLen = CONV_LEN_0;
      3'h1:    convLen = CONV_LEN_1;
      3'h2:    convLen = CONV_LEN_2;
      3'h3:    convLen = CONV_LEN_3;
      3'h4:    convLen = CONV_LEN_4;
      3'h5:    convLen = CONV_LEN_5;
      default: convLen = CONV_LEN_6;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: design/adcs_fifo.sv */
`default_nettype none
module adcs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             wrValid,
  input  wire logic [WIDTH-1:0] wrData,
  output var  logic             wrReady,
  // drain side
  output var  logic             rdValid,
  output var  logic [WIDTH-1:0] rdData,
  input  wire logic             rdReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wPtr_q, wPtr_d, rPtr_q, rPtr_d;
  logic             push, pop;
  logic             notFull_q, notFull_d;

  always_comb begin
    // ready from a flop: full is worked out from the next pointers
    wrReady = notFull_q;
    rdValid = (wPtr_q != rPtr_q);
    rdData  = mem[rPtr_q[AW-1:0]];
    push    = wrValid & wrReady;
    pop     = rdValid & rdReady;
    wPtr_d  = push ? wPtr_q + 1'b1 : wPtr_q;
    rPtr_d  = pop ? rPtr_q + 1'b1 : rPtr_q;
    notFull_d = ~((wPtr_d[AW] != rPtr_d[AW]) &&
                  (wPtr_d[AW-1:0] == rPtr_d[AW-1:0]));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wPtr_q <= '0;
      rPtr_q <= '0;
      notFull_q <= 1'b1;
    end else begin
      wPtr_q <= wPtr_d;
      rPtr_q <= rPtr_d;
      notFull_q <= notFull_d;
    end
  end

  // storage carries no reset: only valid slots are ever read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wPtr_q[AW-1:0]] <= wrData;
    end
  end

endmodule
`default_nettype wire

/* File: design/adcs_rate_gen.sv */
`default_nettype none
module adcs_rate_gen #(
  parameter int OSC_DIV = 100,
  parameter int MOD_DIV = 4
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // ticks
  output var  logic modTick,
  output var  logic modClk
);
  localparam int OW = $clog2(OSC_DIV);
  localparam int MW = $clog2(MOD_DIV);
  localparam logic [OW-1:0] OSC_LAST = OW'(OSC_DIV - 1);
  localparam logic [MW-1:0] MOD_LAST = MW'(MOD_DIV - 1);

  logic [OW-1:0] oscCnt_q, oscCnt_d;
  logic [MW-1:0] modCnt_q, modCnt_d;
  logic          tick_q, tick_d, clk_q, clk_d;

  always_comb begin
    oscCnt_d = (oscCnt_q == OSC_LAST) ? '0 : oscCnt_q + 1'b1;
    modCnt_d = modCnt_q;
    tick_d   = 1'b0;
    if (oscCnt_q == OSC_LAST) begin
      modCnt_d = (modCnt_q == MOD_LAST) ? '0 : modCnt_q + 1'b1;
      tick_d   = (modCnt_q == MOD_LAST);
    end
    // low half first, so the first half period after reset is full length
    clk_d = (modCnt_d >= MW'(MOD_DIV / 2));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oscCnt_q <= '0;
      modCnt_q <= '0;
      tick_q   <= 1'b0;
      clk_q    <= 1'b0;
    end else begin
      oscCnt_q <= oscCnt_d;
      modCnt_q <= modCnt_d;
      tick_q   <= tick_d;
      clk_q    <= clk_d;
    end
  end

  assign modTick = tick_q;
  assign modClk  = clk_q;

endmodule
`default_nettype wire

/* File: test/adcs_ctrl_checker.sv */
`default_nettype none
module adcs_ctrl_checker
  import adcs_pkg::*;
#(
  parameter int TIMEOUT_CYC = 50,
  parameter int FIFO_DEPTH  = 16
) (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       arst_n,
  // serial port
  input wire logic                       sclk,
  input wire logic                       csN,
  input wire logic                       din,
  input wire logic                       serialOutReady,
  input wire logic                       serialOutReadyOe,
  // sample stream
  input wire logic                       smpValid,
  input wire logic [adcs_pkg::RES_BITS-1:0] smpData,
  input wire logic                       smpReady,
  // analog control
  input wire adcs_pkg::adcs_mux_t        muxSel,
  input wire logic                       modClk,
  input wire logic                       powerDown,
  input wire logic                       dataNew
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic [7:0]  halfCnt_q, halfCnt_d;
  logic        seen_q, seen_d, modPrev_q;
  logic [19:0] runCnt_q, runCnt_d;
  always_comb begin
    seen_d    = seen_q | (modClk != modPrev_q);
    halfCnt_d = (modClk != modPrev_q) ? 8'h00 : halfCnt_q + 8'h01;
    // saturates: slow rates overrun no bound here
    runCnt_d  = powerDown ? 20'h00000 : runCnt_q + {19'h0, ~&runCnt_q};
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      halfCnt_q <= 8'h00;
      seen_q    <= 1'b0;
      modPrev_q <= 1'b0;
      runCnt_q  <= 20'h00000;
    end else begin
      halfCnt_q <= halfCnt_d;
      seen_q    <= seen_d;
      modPrev_q <= modClk;
      runCnt_q  <= runCnt_d;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_oe_cs_high: assert property (csN |=> !serialOutReadyOe)
    else $error("output enable still high after select rose");
  a_oe_cs_low: assert property (!csN |=> serialOutReadyOe)
    else $error("output enable low while selected");
  a_sdo_hold_high: assert property (serialOutReadyOe &&
    $past(serialOutReadyOe) && $past(sclk) && $past(sclk, 2)
    |-> $stable(serialOutReady))
    else $error("serial out moved while sclk held high");
  a_modclk_half: assert property ($changed(modClk) && seen_q
    |-> halfCnt_q == 8'd199)
    else $error("modulator clock half period not 200 cycles");
  a_modclk_steady: assert property (seen_q |-> halfCnt_q <= 8'd199)
    else $error("modulator clock stalled");
  a_pd_new_data: assert property ($rose(powerDown)
    |-> ##[0:1] dataNew)
    else $error("powered down without a stored result");
  a_conv_min_len: assert property ($rose(powerDown)
    |-> runCnt_q >= 20'd29601)
    else $error("conversion shorter than the fastest rate allows");
  a_new_held: assert property (dataNew && csN && $past(csN) &&
    $past(csN, 2) |=> dataNew)
    else $error("new data flag lost without a frame");
  a_mux_legal: assert property (!muxSel.negToGnd |->
    (muxSel.posIdx == 2'h0 && muxSel.negIdx == 2'h1) ||
    (muxSel.negIdx == 2'h3 && muxSel.posIdx != 2'h3))
    else $error("illegal differential input pair");
endmodule
bind adcs_ctrl adcs_ctrl_checker #(
  .TIMEOUT_CYC(TIMEOUT_CYC),
  .FIFO_DEPTH (FIFO_DEPTH)
) i_chk (
  .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .csN(csN), .din(din),
  .serialOutReady(serialOutReady), .serialOutReadyOe(serialOutReadyOe),
  .smpValid(smpValid), .smpData(smpData), .smpReady(smpReady),
  .muxSel(muxSel), .modClk(modClk), .powerDown(powerDown),
  .dataNew(dataNew)
);
`default_nettype wire

/* File: test/adcs_host_model.sv */
`default_nettype none
module adcs_host_model (
  // clock
  input  wire logic mclk,
  // serial lines
  output var  logic sclk,
  output var  logic csN,
  output var  logic din,
  input  wire logic serialOutReady,
  input  wire logic serialOutReadyOe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    din  = 1'b0;
  end
  // msb first; fewer than 16 bits leaves a partial frame
  task automatic xfer(input logic [15:0] wr, input int nBits,
                      input bit tieCs, input int half,
                      output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge mclk) #1;
    csN = 1'b0;
    repeat (half) @(posedge mclk);
    #1;
    for (int i = 15; i > 15 - nBits; i--) begin
      sclk = 1'b1;
      din  = wr[i];
      repeat (half) @(posedge mclk);
      #1;
      // captured a half period after the rise
      rd[i] = serialOutReadyOe ? serialOutReady : 1'bx;
      sclk  = 1'b0;
      repeat (half) @(posedge mclk);
      #1;
    end
    din = ~din;
    if (!tieCs) csN = 1'b1;
    repeat (half) @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import adcs_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    logic [4:0] mux;
    logic [4:0] msk;
  } adcs_row_t;
  adcs_row_t rows [8] = '{'{3'h0, 5'h02, 5'h1F}, '{3'h1, 5'h06, 5'h1F},
    '{3'h2, 5'h0E, 5'h1F}, '{3'h3, 5'h16, 5'h1F}, '{3'h4, 5'h01, 5'h19},
    '{3'h5, 5'h09, 5'h19}, '{3'h6, 5'h11, 5'h19}, '{3'h7, 5'h19, 5'h19}};
  logic            mclk, arst_n, sclk, csN, din, sdo, sdoOe;
  logic            smpValid, smpReady, modClk, powerDown, dataNew;
  logic [11:0]     smpData;
  adcs_mux_t       muxSel;
  logic [15:0]     rd;
  int              num_errors, check_count, el;
  time             t0;
  adcs_ctrl #(.TIMEOUT_CYC(50), .FIFO_DEPTH(16)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .csN(csN), .din(din),
    .serialOutReady(sdo), .serialOutReadyOe(sdoOe), .smpValid(smpValid),
    .smpData(smpData), .smpReady(smpReady), .muxSel(muxSel),
    .modClk(modClk), .powerDown(powerDown), .dataNew(dataNew));
  adcs_host_model i_host (.mclk(mclk), .sclk(sclk), .csN(csN), .din(din),
    .serialOutReady(sdo), .serialOutReadyOe(sdoOe));
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic push(input logic [11:0] d);
    int n;
    n = 0;
    smpValid = 1'b1;
    smpData  = d;
    while (smpReady !== 1'b1 && n < 2000) begin
      n++;
      @(posedge mclk) #1;
    end
    if (smpReady !== 1'b1) begin
      num_errors++;
      $display("[FAIL] smpReady expected 1 seen 0");
    end
    // valid stays up: the caller drops it after the last word
    @(posedge mclk) #1;
  endtask
  task automatic waitNew();
    int n;
    n = 0;
    while (dataNew !== 1'b1 && n < 40000) begin
      n++;
      @(posedge mclk) #1;
    end
    if (dataNew !== 1'b1) begin
      num_errors++;
      $display("[FAIL] dataNew expected 1 seen 0");
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #1_000_000;
    num_errors++;
    $display("[FAIL] watchdog expected end seen timeout");
    summarize();
  end
  initial begin
    arst_n   = 1'b0;
    smpValid = 1'b0;
    smpData  = 12'h000;
    repeat (4) @(posedge mclk);
    #1;
    check("reset", 16'h0512, {5'h0, sdo, sdoOe, smpReady, muxSel,
      modClk, powerDown, dataNew});
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    $display("test reset finished");
    foreach (rows[i]) begin
      i_host.xfer({1'b0, rows[i].sel, 4'h1, 8'hC0}, 16, 1'b0, 3, rd);
      check("muxSel", 16'(rows[i].mux), 16'(muxSel & rows[i].msk));
      check("powerDown", 16'h0001, 16'(powerDown));
    end
    $display("test mux finished");
    i_host.xfer(16'hFFFF, 5, 1'b1, 3, rd);
    repeat (60) @(posedge mclk);
    i_host.xfer(16'h51C0, 16, 1'b1, 2, rd);
    check("muxSel", 16'h0009, 16'(muxSel & 5'h19));
    $display("test timeout finished");
    for (int i = 0; i < 16; i++) push(12'(i + 1));
    smpValid = 1'b1;
    smpData  = 12'h800;
    repeat (2) @(posedge mclk);
    #1;
    check("smpReady", 16'h0000, 16'(smpReady));
    i_host.xfer(16'hC1C0, 16, 1'b0, 3, rd);
    t0 = $time;
    check("powerDown", 16'h0000, 16'(powerDown));
    push(12'h800);
    smpValid = 1'b0;
    repeat (5000) @(posedge mclk);
    i_host.xfer(16'hC1C0, 16, 1'b0, 3, rd);
    waitNew();
    el = int'(($time - t0) / 10);
    check("oneConv", 16'h0001, 16'(el >= 29596 && el <= 29995));
    check("powerDown", 16'h0001, 16'(powerDown));
    i_host.xfer(16'h01C0, 16, 1'b0, 6, rd);
    check("result", 16'h0000, rd);
    check("dataNew", 16'h0000, 16'(dataNew));
    repeat (500) @(posedge mclk);
    #1;
    check("powerDown", 16'h0001, 16'(powerDown));
    $display("test single finished");
    push(12'h9AB);
    smpValid = 1'b0;
    i_host.xfer(16'h00C0, 16, 1'b0, 3, rd);
    waitNew();
    t0 = $time;
    i_host.xfer(16'h00C0, 16, 1'b0, 3, rd);
    check("result", 16'h9AB0, rd);
    waitNew();
    el = int'(($time - t0) / 10);
    check("period", 16'h0001, 16'(el >= 29999 && el <= 30001));
    check("powerDown", 16'h0000, 16'(powerDown));
    $display("test continuous finished");
    summarize();
  end
endmodule
`default_nettype wire
